/* sacx_top.sv */
// sequencer for the successive-approximation converter
`include "sacx_defs.svh"
module sacx_top #(
  parameter int RES_BITS = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input sacx_pkg::sacx_cfg_s cfg,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic low_speed_clock,
  input wire logic [2:0] analog_input_four_first_func,
  input wire logic [2:0] analog_input_four_second_func,
  input wire logic comparator_high,
  input wire logic stop_mode_req,
  input wire logic [4:0] result_index,
  output logic conversion_run_flag,
  output logic stop_mode_grant,
  output logic sample_hold,
  output logic [RES_BITS-1:0] dac_code,
  output logic [4:0] active_channel,
  output logic analog_input_four_first_sel,
  output logic analog_input_four_second_sel,
  output logic [RES_BITS-1:0] result_data,
  output logic result_strobe,
  output sacx_pkg::sacx_result_s last_result
);
  import sacx_pkg::*;

  generate
    if (RES_BITS != 10)
    begin : g_chk
      $error("result width must match the result struct");
    end
  endgenerate

  localparam int CH = `SACX_CH_COUNT;

  // =====================================================
  // lowest enabled channel at or above a start index
  function automatic logic [5:0] next_ch(
    input logic [CH-1:0] mask,
    input logic [4:0] from
  );
    logic [5:0] r;
    r = 6'h00;
    for (int i = CH - 1; i >= 0; i--)
    begin
      if (mask[i] && (i >= int'(from)))
      begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic is_analog(input logic [2:0] f);
    return (f == `SACX_PIN_FUNC_6TH) || (f == `SACX_PIN_FUNC_8TH);
  endfunction

  sacx_state_e state_ff;
  sacx_state_e nxt_state;
  logic run_ff;
  logic nxt_run;
  logic [4:0] ch_ff;
  logic [4:0] nxt_ch;
  logic [3:0] smp_ff;
  logic [3:0] nxt_smp;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic [RES_BITS-1:0] code_ff;
  logic [RES_BITS-1:0] nxt_code;
  logic cmp_meta_ff;
  logic cmp_sync_ff;
  logic [RES_BITS-1:0] res_mem_ff [CH];
  logic [RES_BITS-1:0] rd_ff;
  logic strobe_ff;
  sacx_result_s last_ff;
  logic tick;
  logic [CH-1:0] ch_mask;
  logic any_sel;
  logic temp_only;
  logic [5:0] first_hit;
  logic [5:0] after_hit;
  logic last_bit;
  logic store_now;
  logic [RES_BITS-1:0] trial_bit;

  // =====================================================
  // channel decode
  assign ch_mask = {cfg.channel_enable_high, cfg.channel_enable_low};
  assign any_sel = |ch_mask;
  assign temp_only = (ch_mask == (CH'(1) << `SACX_TEMP_CH));
  assign first_hit = next_ch(ch_mask, 5'h00);
  assign after_hit = next_ch(ch_mask, ch_ff + 5'h01);
  assign last_bit = (bit_ff == 4'h0);
  assign trial_bit = RES_BITS'(1) << bit_ff;
  assign store_now = (state_ff == SACX_STORE);

  // =====================================================
  // conversion clock
  sacx_tick_gen #(
    .DIV_W(6)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .low_speed_clock(low_speed_clock),
    .clock_select(cfg.conversion_clock_select),
    .temp_only(temp_only),
    .tick(tick)
  );

  // =====================================================
  // input four pin choice and stop-mode gate
  assign analog_input_four_first_sel = is_analog(analog_input_four_first_func);
  assign analog_input_four_second_sel = is_analog(analog_input_four_second_func) &&
                           !is_analog(analog_input_four_first_func);
  assign stop_mode_grant = stop_mode_req && !run_ff;

  // =====================================================
  // run flag
  always_comb
  begin
    nxt_run = run_ff;
    if (store_now && tick && !cfg.continuous_mode_bit &&
        !after_hit[5])
    begin
      nxt_run = 1'b0;
    end
    if (start_req && any_sel)
    begin
      nxt_run = 1'b1;
    end
    if (stop_req)
    begin
      nxt_run = 1'b0;
    end
  end

  // =====================================================
  // sequencer, steps on conversion ticks
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ch = ch_ff;
    nxt_smp = smp_ff;
    nxt_bit = bit_ff;
    nxt_settle = settle_ff;
    nxt_code = code_ff;
    if (settle_ff != 2'h0)
    begin
      nxt_settle = settle_ff - 2'h1;
    end
    if (state_ff != SACX_IDLE && !run_ff && tick)
    begin
      nxt_state = SACX_IDLE;
    end
    else if (tick)
    begin
      unique case (state_ff)
        SACX_IDLE:
        begin
          if (run_ff && first_hit[4:0] < 5'(CH) && any_sel)
          begin
            nxt_state = SACX_SAMPLE;
            nxt_ch = first_hit[4:0];
            nxt_smp = `SACX_SAMPLE_TICKS;
          end
        end
        SACX_SAMPLE:
        begin
          nxt_smp = smp_ff - 4'h1;
          if (smp_ff == 4'h1)
          begin
            nxt_state = SACX_CONVERT;
            nxt_bit = 4'(RES_BITS - 1);
            nxt_code = RES_BITS'(1) << (RES_BITS - 1);
            nxt_settle = `SACX_CMP_SETTLE;
          end
        end
        SACX_CONVERT:
        begin
          if (settle_ff == 2'h0)
          begin
            nxt_code = cmp_sync_ff ? code_ff : (code_ff & ~trial_bit);
            nxt_settle = `SACX_CMP_SETTLE;
            if (last_bit)
            begin
              nxt_state = SACX_STORE;
            end
            else
            begin
              nxt_bit = bit_ff - 4'h1;
              nxt_code = nxt_code | (trial_bit >> 1);
            end
          end
        end
        SACX_STORE:
        begin
          nxt_state = SACX_SAMPLE;
          nxt_smp = `SACX_SAMPLE_TICKS;
          nxt_ch = after_hit[5] ? after_hit[4:0] : first_hit[4:0];
          if (!after_hit[5] && !cfg.continuous_mode_bit)
          begin
            nxt_state = SACX_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================
  // outputs
  assign conversion_run_flag = run_ff;
  assign sample_hold = (state_ff == SACX_SAMPLE);
  assign dac_code = code_ff;
  assign active_channel = ch_ff;
  assign result_data = rd_ff;
  assign result_strobe = strobe_ff;
  assign last_result = last_ff;

  // =====================================================
  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= SACX_IDLE;
      run_ff <= 1'b0;
      ch_ff <= 5'h00;
      smp_ff <= 4'h0;
      bit_ff <= 4'h0;
      settle_ff <= 2'h0;
      code_ff <= '0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
      rd_ff <= '0;
      strobe_ff <= 1'b0;
      last_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      run_ff <= nxt_run;
      ch_ff <= nxt_ch;
      smp_ff <= nxt_smp;
      bit_ff <= nxt_bit;
      settle_ff <= nxt_settle;
      code_ff <= nxt_code;
      cmp_meta_ff <= comparator_high;
      cmp_sync_ff <= cmp_meta_ff;
      rd_ff <= (result_index < 5'(CH)) ? res_mem_ff[result_index] : '0;
      strobe_ff <= store_now && tick && run_ff;
      if (store_now && tick && run_ff)
      begin
        last_ff <= '{channel: ch_ff, data: code_ff};
      end
    end
  end

  // =====================================================
  // per-channel result storage
  generate
    for (genvar g = 0; g < CH; g++)
    begin : g_res
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          res_mem_ff[g] <= '0;
        end
        else if (store_now && tick && run_ff && ch_ff == 5'(g))
        begin
          res_mem_ff[g] <= code_ff;
        end
      end
    end
  endgenerate

endmodule // sacx_top

/* sacx_defs.svh */
// constants for the successive-approximation converter sequencer
// Operation
// - no selected channel: start refused, flag stays
// - low-power stop refused while run flag set
// - low-speed clock: start/stop lag up to three
// - temperature only at undivided clock: halve rate
// - input four from first pin when both
`ifndef SACX_DEFS_SVH
`define SACX_DEFS_SVH

// =====================================================
// channels
`define SACX_CH_COUNT 19
`define SACX_CH_IDX_W 5
`define SACX_TEMP_CH 5'h10
`define SACX_TEST_CH 5'h12

// =====================================================
// conversion clock select codes
`define SACX_CLK_DIV1 3'h0
`define SACX_CLK_HALF 3'h1
`define SACX_CLK_LOW_SPEED 3'h7

// =====================================================
// pin function codes for analog use
`define SACX_PIN_FUNC_6TH 3'h5
`define SACX_PIN_FUNC_8TH 3'h7

// =====================================================
// timing counts, in conversion ticks or clk cycles
`define SACX_SAMPLE_TICKS 4'h4
`define SACX_CMP_SETTLE 2'h3

`endif

/* sacx_pkg.sv */
// types shared by the converter sequencer
package sacx_pkg;

  // =====================================================
  // configuration carried from the control bits
  typedef struct packed {
    logic [15:0] channel_enable_low;
    logic [2:0] channel_enable_high;
    logic continuous_mode_bit;
    logic [2:0] conversion_clock_select;
  } sacx_cfg_s;

  // =====================================================
  // most recent stored conversion
  typedef struct packed {
    logic [4:0] channel;
    logic [9:0] data;
  } sacx_result_s;

  typedef enum logic [1:0] {
    SACX_IDLE,
    SACX_SAMPLE,
    SACX_CONVERT,
    SACX_STORE
  } sacx_state_e;

endpackage

/* sacx_tick_gen.sv */
// conversion clock tick generator
`include "sacx_defs.svh"
module sacx_tick_gen #(
  parameter int DIV_W = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic low_speed_clock,
  input wire logic [2:0] clock_select,
  input wire logic temp_only,
  output logic tick
);
  import sacx_pkg::*;

  generate
    if (DIV_W < 6)
    begin : g_chk
      $error("divider too narrow for select codes");
    end
  endgenerate

  logic ls_meta_ff;
  logic ls_sync_ff;
  logic ls_prev_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic tick_ff;
  logic [2:0] eff_sel;
  logic [DIV_W-1:0] mask;
  logic ls_edge;
  logic div_tick;
  logic nxt_tick;

  // =====================================================
  // tick select
  assign eff_sel = (clock_select == `SACX_CLK_DIV1 && temp_only) ?
                   `SACX_CLK_HALF : clock_select;
  assign mask = ~({DIV_W{1'b1}} << eff_sel);
  assign div_tick = &(cnt_ff | ~mask);
  assign ls_edge = ls_sync_ff & ~ls_prev_ff;
  assign nxt_tick = (clock_select == `SACX_CLK_LOW_SPEED) ?
                    ls_edge : div_tick;
  assign tick = tick_ff;

  // =====================================================
  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ls_meta_ff <= 1'b0;
      ls_sync_ff <= 1'b0;
      ls_prev_ff <= 1'b0;
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      ls_meta_ff <= low_speed_clock;
      ls_sync_ff <= ls_meta_ff;
      ls_prev_ff <= ls_sync_ff;
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= nxt_tick;
    end
  end

endmodule // sacx_tick_gen

/* sacx_asserts.sv */
// assertions for the converter sequencer
`include "sacx_defs.svh"
module sacx_chk #(
  parameter int SLOW_CYC = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input sacx_pkg::sacx_cfg_s cfg,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic stop_mode_req,
  input wire logic [2:0] analog_input_four_first_func,
  input wire logic [2:0] analog_input_four_second_func,
  input wire logic conversion_run_flag,
  input wire logic stop_mode_grant,
  input wire logic analog_input_four_first_sel,
  input wire logic analog_input_four_second_sel,
  input wire logic sample_hold,
  input wire logic result_strobe
);
  import sacx_pkg::*;
  localparam int LAG = 3 * SLOW_CYC;
  logic any_ch;
  logic a1;
  logic a2;
  assign any_ch = |{cfg.channel_enable_high, cfg.channel_enable_low};
  assign a1 = analog_input_four_first_func == `SACX_PIN_FUNC_6TH
    || analog_input_four_first_func == `SACX_PIN_FUNC_8TH;
  assign a2 = analog_input_four_second_func == `SACX_PIN_FUNC_6TH
    || analog_input_four_second_func == `SACX_PIN_FUNC_8TH;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // =========
  // assertions
  AST_REFUSE: assert property (
    start_req && !conversion_run_flag && !any_ch |=> !conversion_run_flag)
    else $error("start taken without channel");
  AST_ACCEPT: assert property (
    start_req && !stop_req && any_ch |=> conversion_run_flag)
    else $error("start not taken");
  AST_STOP_BLOCK: assert property (
    conversion_run_flag |-> !stop_mode_grant)
    else $error("stop granted while running");
  AST_STOP_GRANT: assert property (
    stop_mode_req && !conversion_run_flag |-> stop_mode_grant)
    else $error("stop refused while idle");
  AST_ANALOG_INPUT_FOUR: assert property (
    a1 && a2 |-> analog_input_four_first_sel && !analog_input_four_second_sel)
    else $error("input four took second pin");
  AST_SLOW_START: assert property (
    $rose(conversion_run_flag)
    && cfg.conversion_clock_select == `SACX_CLK_LOW_SPEED
    |-> ##[1:LAG] sample_hold)
    else $error("slow start lag too long");
  AST_CONT_HOLD: assert property (
    $fell(conversion_run_flag) && cfg.continuous_mode_bit |-> $past(stop_req))
    else $error("continuous run ended itself");

  // =========
  // covers
  COV_START: cover property (start_req && any_ch ##1 conversion_run_flag);
  COV_STORE: cover property (result_strobe);
  COV_END: cover property (
    $fell(conversion_run_flag) && !cfg.continuous_mode_bit);
endmodule // sacx_chk

bind sacx_top sacx_chk u_sacx_chk (.clk, .arst_n, .cfg, .start_req,
  .stop_req, .stop_mode_req, .analog_input_four_first_func, .analog_input_four_second_func,
  .conversion_run_flag, .stop_mode_grant, .analog_input_four_first_sel,
  .analog_input_four_second_sel, .sample_hold, .result_strobe);

/* sacx_analog_model.sv */
// analog input and comparator model
module sacx_analog_model #(
  parameter logic [9:0] LEVEL = 10'h2a5
) (
  input wire logic clk,
  input wire logic [9:0] dac_code,
  output logic comparator_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // steady input, reference and amplifier settled
  // sensor on, test mode set, amp mode fixed
  always_ff @(posedge clk)
  begin
    comparator_high <= (LEVEL >= dac_code);
  end
endmodule // sacx_analog_model

/* test_sacx_top.sv */
// self-checking bench for the converter sequencer
`include "sacx_defs.svh"
module test_sacx_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sacx_pkg::*;
  localparam logic [9:0] LVL = 10'h2a5;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic lsc = 1'b0;
  sacx_cfg_s cfg = '0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic smr = 1'b0;
  logic [2:0] f1 = 3'h0;
  logic [2:0] f2 = 3'h0;
  logic [4:0] idx = 5'h00;
  logic cmp, run, grant, sh, sel1, sel2, strobe;
  logic [9:0] dac, rdata;
  logic [4:0] ach;
  sacx_result_s last;
  int n_errors = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;
  initial
  begin
    #1.3;
    forever #50 lsc = ~lsc;
  end

  sacx_top u_sacx_top (.clk(clk), .arst_n(arst_n), .cfg(cfg),
    .start_req(start_req), .stop_req(stop_req), .low_speed_clock(lsc),
    .analog_input_four_first_func(f1), .analog_input_four_second_func(f2), .comparator_high(cmp),
    .stop_mode_req(smr), .result_index(idx), .conversion_run_flag(run),
    .stop_mode_grant(grant), .sample_hold(sh), .dac_code(dac),
    .active_channel(ach), .analog_input_four_first_sel(sel1), .analog_input_four_second_sel(sel2),
    .result_data(rdata), .result_strobe(strobe), .last_result(last));
  sacx_analog_model #(.LEVEL(LVL)) u_sacx_analog_model (.clk(clk),
    .dac_code(dac), .comparator_high(cmp));

  // =========
  // helpers
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wt(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk(n < 3000, "wait timed out");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // =========
  // scenarios
  task automatic t_refuse;
    cfg = '0;
    pulse(start_req);
    cyc(2);
    chk(run === 1'b0, "start taken with no channel");
  endtask
  task automatic t_single;
    int n;
    cfg = '0;
    cfg.channel_enable_low = 16'h0008;
    smr = 1'b1;
    pulse(start_req);
    chk(run === 1'b1 && grant === 1'b0, "stop not blocked");
    wt(sh, 1'b1, n);
    chk(ach === 5'h03, "wrong channel sampled");
    wt(strobe, 1'b1, n);
    cyc(1);
    chk(last === {5'h03, LVL} && dac === LVL, "stored result wrong");
    wt(run, 1'b0, n);
    chk(grant === 1'b1, "stop refused when idle");
    smr = 1'b0;
    idx = 5'h03;
    cyc(1);
    chk(rdata === LVL, "read of channel three");
    idx = 5'h14;
    cyc(1);
    chk(rdata === 10'h000, "read past last channel");
  endtask
  task automatic sh_width(input logic [18:0] ch, output int w);
    int n;
    cfg = '0;
    {cfg.channel_enable_high, cfg.channel_enable_low} = ch;
    pulse(start_req);
    wt(sh, 1'b1, n);
    wt(sh, 1'b0, w);
    wt(run, 1'b0, n);
  endtask
  task automatic t_temp;
    int a;
    int b;
    sh_width(19'h00008, a);
    sh_width(19'h10000, b);
    chk(a == int'(`SACX_SAMPLE_TICKS) && b == 2 * a,
        "temperature rate not halved");
  endtask
  task automatic t_slow;
    int n;
    cfg = '0;
    cfg.channel_enable_low = 16'h0004;
    cfg.conversion_clock_select = `SACX_CLK_LOW_SPEED;
    pulse(start_req);
    wt(sh, 1'b1, n);
    chk(n <= 60, "slow start lag");
    pulse(stop_req);
    chk(run === 1'b0, "stop not taken");
    wt(sh, 1'b0, n);
    chk(n <= 60, "slow stop lag");
    cyc(100);
  endtask
  task automatic t_cont;
    int n;
    logic [4:0] exp_ch[3];
    exp_ch = '{5'h01, 5'h02, 5'h01};
    cfg = '0;
    cfg.channel_enable_low = 16'h0006;
    cfg.continuous_mode_bit = 1'b1;
    pulse(start_req);
    for (int k = 0; k < 3; k++)
    begin
      wt(strobe, 1'b1, n);
      cyc(1);
      chk(last.channel === exp_ch[k] && last.data === LVL,
          "scan order wrong");
    end
    chk(run === 1'b1, "continuous run ended");
    pulse(stop_req);
    chk(run === 1'b0, "stop not taken");
    cyc(20);
  endtask
  task automatic t_analog_input_four;
    logic [2:0] c[3];
    c = '{`SACX_PIN_FUNC_6TH, `SACX_PIN_FUNC_8TH, 3'h0};
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++)
      begin
        f1 = c[i];
        f2 = c[j];
        cyc(1);
        chk(sel1 === (i < 2) && sel2 === (i == 2 && j < 2), "pin pick");
      end
  endtask

  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    cyc(2);
    arst_n = 1'b1;
    cyc(1);
    t_refuse();
    t_single();
    t_temp();
    t_slow();
    t_cont();
    t_analog_input_four();
    end_sim();
  end
endmodule // test_sacx_top
